/* File: pmc_pkg.sv */
// Constants, field layouts and carriers for the physical memory protection
// checker. Assumes one hart clock and one hart reset shared by all users.
`default_nettype none

package pmc_pkg;

  // Geometry
  localparam int ENTRY_N   = 16;          // Implemented entries
  localparam int IDX_W     = 4;           // Entry index width
  localparam int ADDR_W    = 32;          // Address register width
  localparam int PA_W      = 34;          // Physical address width
  localparam int GRAIN_G   = 2;           // Grain is 2^(G+2) bytes

  // Low address bits shaped by the grain
  localparam logic [31:0] TOP_IGNORE_MASK = 32'h0000_0003; // Bits G-1:0
  localparam logic [31:0] POW2_ONES_MASK  = 32'h0000_0001; // Bits G-2:0

  // Match modes
  localparam logic [1:0] MODE_OFF  = 2'h0;
  localparam logic [1:0] MODE_TOP  = 2'h1;
  localparam logic [1:0] MODE_FOUR = 2'h2;
  localparam logic [1:0] MODE_POW2 = 2'h3;

  // Privilege encodings
  localparam logic [1:0] PRIV_U = 2'h0;
  localparam logic [1:0] PRIV_S = 2'h1;
  localparam logic [1:0] PRIV_M = 2'h3;

  // Access kinds, also the fault kind reported
  localparam logic [1:0] KIND_FETCH = 2'h0;
  localparam logic [1:0] KIND_LOAD  = 2'h1;
  localparam logic [1:0] KIND_STORE = 2'h2;

  // Register byte offsets
  localparam logic [7:0] OFS_CFG_BASE  = 8'h00; // 16 words of config
  localparam logic [7:0] OFS_ADDR_BASE = 8'h40; // 16 words of address
  localparam logic [7:0] OFS_STATUS    = 8'h80; // Last verdict

  // Reset values
  localparam logic [7:0]  CFG_RESET  = 8'h00;
  localparam logic [31:0] ADDR_RESET = 32'h0000_0000;

  // Configuration byte layout
  typedef struct packed {
    logic       lock;
    logic [1:0] resv;
    logic [1:0] mode;
    logic       exec;
    logic       wr;
    logic       rd;
  } pmc_cfg_t;

  // Access presented for checking
  typedef struct packed {
    logic            valid;
    logic [1:0]      kind;
    logic            walk;
    logic [1:0]      priv;
    logic [PA_W-1:0] addr;
    logic [1:0]      sizeLog2;
  } pmc_req_t;

  // Verdict
  typedef struct packed {
    logic       valid;
    logic       fault;
    logic [1:0] faultKind;
  } pmc_resp_t;

endpackage

`default_nettype wire

/* File: pmc_entry.sv */
// One protection entry: decides whether an access range touches the
// entry's region at all, and whether it lies wholly inside it.
// Assumes access bounds are inclusive byte addresses, hi not below lo.
`default_nettype none

module pmc_entry (
  // Entry state
  input  wire pmc_pkg::pmc_cfg_t          cfg,
  input  wire logic [pmc_pkg::ADDR_W-1:0] addrReg,
  input  wire logic [pmc_pkg::ADDR_W-1:0] prevAddr,
  // Access range
  input  wire logic [pmc_pkg::PA_W:0]     accLo,
  input  wire logic [pmc_pkg::PA_W:0]     accHi,
  // Result
  output var  logic                       anyHit,
  output var  logic                       allHit
);

  logic [31:0] pow2A;    // Address with grain bits forced to ones
  logic [32:0] pow2M;    // Trailing ones plus the next bit
  logic [33:0] baseW;    // Region base in words
  logic [33:0] topW;     // Region end in words, exclusive
  logic        en;       // Region is live
  logic [35:0] baseB;    // Region base in bytes
  logic [35:0] topB;     // Region end in bytes
  logic [35:0] loB;      // Access bounds widened
  logic [35:0] hiB;

  // Region bounds from the mode; word units keep the all-ones case exact
  always_comb begin
    pow2A  = addrReg | pmc_pkg::POW2_ONES_MASK;
    pow2M  = {1'b0, pow2A} ^ ({1'b0, pow2A} + 33'h0_0000_0001);
    baseW  = 34'h0;
    topW   = 34'h0;
    en     = 1'b0;
    case (cfg.mode)
      pmc_pkg::MODE_TOP: begin
        // Low grain bits take no part in the bounds
        baseW = {2'h0, prevAddr & ~pmc_pkg::TOP_IGNORE_MASK};
        topW  = {2'h0, addrReg & ~pmc_pkg::TOP_IGNORE_MASK};
        en    = baseW < topW;
      end
      pmc_pkg::MODE_FOUR: begin
        baseW = {2'h0, addrReg};
        topW  = baseW + 34'h1;
        en    = 1'b1;
      end
      pmc_pkg::MODE_POW2: begin
        baseW = {2'h0, pow2A} & ~{1'b0, pow2M};
        topW  = baseW + {1'b0, pow2M} + 34'h1;
        en    = 1'b1;
      end
      default: begin
        en = 1'b0;
      end
    endcase
  end

  // Zero-extended byte comparison against the physical range
  always_comb begin
    baseB  = {baseW, 2'h0};
    topB   = {topW, 2'h0};
    loB    = {1'b0, accLo};
    hiB    = {1'b0, accHi};
    anyHit = en && (loB < topB) && (hiB >= baseB);
    allHit = en && (loB >= baseB) && (hiB < topB);
  end

endmodule

`default_nettype wire

/* File: pmc_checker.sv */
// Top of the physical memory protection checker: sixteen entries held in
// registers, a machine-mode register port and a one-access-per-cycle check.
// Assumes the register port is only driven by machine-mode software and
// that all inputs are synchronous to ref_clk.
//
// The register addresses and the strobed register port were left to the implementer.
`default_nettype none

module pmc_checker (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Register port
  input  wire logic [7:0]        regAddr,
  input  wire logic [31:0]       regWrData,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output var  logic [31:0]       regRdData,
  // Access check
  input  wire pmc_pkg::pmc_req_t chkReq,
  output var  pmc_pkg::pmc_resp_t chkResp
);

  localparam int N = pmc_pkg::ENTRY_N;

  // Entry storage; address bits are kept raw whatever the mode
  pmc_pkg::pmc_cfg_t        cfg   [N];
  logic [pmc_pkg::ADDR_W-1:0] addrR [N];

  // Decode of the register port
  logic [5:0]  wordIdx;     // Word index within the map
  logic        selCfg;      // Config window
  logic        selAddr;     // Address window
  logic        selStatus;   // Status word
  logic [3:0]  entIdx;      // Entry addressed

  // Write legalisation
  pmc_pkg::pmc_cfg_t next_cfg;   // Legalised config byte
  logic              cfgWrOk;    // Config write allowed
  logic              addrWrOk;   // Address write allowed

  // Access range and per-entry match
  logic [pmc_pkg::PA_W:0] accLo;
  logic [pmc_pkg::PA_W:0] accHi;
  logic [N-1:0]           anyHit;
  logic [N-1:0]           allHit;

  // Verdict combinational terms
  logic [1:0]  effPriv;       // Privilege used for the check
  logic        hitFound;      // Some entry touched the access
  logic [3:0]  hitIdx;        // Highest-priority touching entry
  logic        permOk;        // Permission bit for this kind
  logic        next_fault;

  // Status captured from the last checked access
  logic        lastValid;
  logic        lastFault;
  logic        lastHit;
  logic [3:0]  lastIdx;

  // Byte-offset decode; low two address bits are ignored
  always_comb begin
    wordIdx   = regAddr[7:2];
    selCfg    = regAddr[7:6] == pmc_pkg::OFS_CFG_BASE[7:6];
    selAddr   = regAddr[7:6] == pmc_pkg::OFS_ADDR_BASE[7:6];
    selStatus = regAddr[7:2] == pmc_pkg::OFS_STATUS[7:2];
    entIdx    = wordIdx[3:0];
  end

  // Legalise a config byte before storing it
  always_comb begin
    next_cfg      = pmc_pkg::pmc_cfg_t'(regWrData[7:0]);
    next_cfg.resv = 2'h0;
    // Read-clear with write-set is reserved, so the write bit is dropped
    if (!next_cfg.rd && next_cfg.wr) begin
      next_cfg.wr = 1'b0;
    end
    // A coarse grain cannot express four bytes; keep the old mode then
    if (pmc_pkg::GRAIN_G >= 1 && next_cfg.mode == pmc_pkg::MODE_FOUR) begin
      next_cfg.mode = cfg[entIdx].mode;
    end
  end

  // Lock gating of writes
  always_comb begin
    cfgWrOk  = !cfg[entIdx].lock;
    addrWrOk = !cfg[entIdx].lock;
    // The next entry's lower bound lives here when it is a locked top range
    if (entIdx != 4'(N - 1)) begin
      if (cfg[entIdx + 4'h1].lock &&
          cfg[entIdx + 4'h1].mode == pmc_pkg::MODE_TOP) begin
        addrWrOk = 1'b0;
      end
    end
  end

  // Config bytes; the lock holds until reset since nothing else clears it
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        cfg[i] <= pmc_pkg::pmc_cfg_t'(pmc_pkg::CFG_RESET);
      end
    end else if (regWr && selCfg && cfgWrOk) begin
      cfg[entIdx] <= next_cfg;
    end
  end

  // Address registers store every written bit; shaping is on read and in the entry match
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < N; i++) begin
        addrR[i] <= pmc_pkg::ADDR_RESET;
      end
    end else if (regWr && selAddr && addrWrOk) begin
      addrR[entIdx] <= regWrData;
    end
  end

  // Read data one cycle after the strobe; unmapped words read zero
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      regRdData <= 32'h0;
    end else if (regRd) begin
      if (selCfg) begin
        regRdData <= {24'h0, cfg[entIdx]};
      end else if (selAddr) begin
        // Readback shows the grain: the value software uses to find it
        if (cfg[entIdx].mode[1]) begin
          regRdData <= addrR[entIdx] | pmc_pkg::POW2_ONES_MASK;
        end else begin
          regRdData <= addrR[entIdx] & ~pmc_pkg::TOP_IGNORE_MASK;
        end
      end else if (selStatus) begin
        regRdData <= {15'h0, lastHit, 4'h0, lastIdx,
                      6'h0, lastFault, lastValid};
      end else begin
        regRdData <= 32'h0;
      end
    end else begin
      regRdData <= 32'h0;
    end
  end

  // Inclusive byte range of the access; one wider to avoid wrap
  always_comb begin
    accLo = {1'b0, chkReq.addr};
    accHi = accLo + ((pmc_pkg::PA_W + 1)'(1) << chkReq.sizeLog2)
            - (pmc_pkg::PA_W + 1)'(1);
  end

  // All entries compared side by side; entry zero's lower bound is zero
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : gEnt
      pmc_entry uEnt (
        .cfg      (cfg[g]),
        .addrReg  (addrR[g]),
        .prevAddr ((g == 0) ? 32'h0 : addrR[(g == 0) ? 0 : g - 1]),
        .accLo    (accLo),
        .accHi    (accHi),
        .anyHit   (anyHit[g]),
        .allHit   (allHit[g])
      );
    end
  endgenerate

  // Effective privilege: page-table walks count as supervisor
  always_comb begin
    effPriv = chkReq.walk ? pmc_pkg::PRIV_S : chkReq.priv;
  end

  // Priority pick: scan high to low so the lowest index wins
  always_comb begin
    hitFound = 1'b0;
    hitIdx   = 4'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (anyHit[i]) begin
        hitFound = 1'b1;
        hitIdx   = 4'(i);
      end
    end
  end

  // Permission bit matching the access kind
  always_comb begin
    case (chkReq.kind)
      pmc_pkg::KIND_FETCH: permOk = cfg[hitIdx].exec;
      pmc_pkg::KIND_LOAD:  permOk = cfg[hitIdx].rd;
      pmc_pkg::KIND_STORE: permOk = cfg[hitIdx].wr;
      default:             permOk = 1'b0;
    endcase
  end

  // Verdict
  always_comb begin
    if (!hitFound) begin
      // With no entry touched, even before any is set, lower modes get nothing by default
      next_fault = effPriv != pmc_pkg::PRIV_M;
    end else if (!allHit[hitIdx]) begin
      next_fault = 1'b1;
    end else if (!cfg[hitIdx].lock && effPriv == pmc_pkg::PRIV_M) begin
      next_fault = 1'b0;
    end else begin
      next_fault = !permOk;
    end
  end

  // Registered verdict; the fault kind follows the access kind
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      chkResp <= '0;
    end else begin
      chkResp.valid     <= chkReq.valid;
      chkResp.fault     <= chkReq.valid && next_fault;
      chkResp.faultKind <= chkReq.kind;
    end
  end

  // Status word for software inspection of the last check
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      lastValid <= 1'b0;
      lastFault <= 1'b0;
      lastHit   <= 1'b0;
      lastIdx   <= 4'h0;
    end else if (chkReq.valid) begin
      lastValid <= 1'b1;
      lastFault <= next_fault;
      lastHit   <= hitFound;
      lastIdx   <= hitIdx;
    end
  end

endmodule

`default_nettype wire

/* File: pmc_checker_monitor.sv */
// Port checker for pmc_checker: register readback shape and verdict timing.
// Assumes it is bound to every pmc_checker and sees only its ports.
`default_nettype none

module pmc_checker_monitor (
  // Clock and reset
  input wire logic               ref_clk,
  input wire logic               rst,
  // Register port
  input wire logic [7:0]         regAddr,
  input wire logic [31:0]        regWrData,
  input wire logic               regWr,
  input wire logic               regRd,
  input wire logic [31:0]        regRdData,
  // Access check
  input wire pmc_pkg::pmc_req_t  chkReq,
  input wire pmc_pkg::pmc_resp_t chkResp
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // Until the first write no entry can match, so the default verdict holds
  logic wrSeen;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wrSeen <= 1'b0;
    end else if (regWr) begin
      wrSeen <= 1'b1;
    end
  end

  // Read of a configuration word, then of an address word
  sequence cfgRead;
    regRd && regAddr < 8'h40;
  endsequence
  sequence addrRead;
    regRd && regAddr >= 8'h40 && regAddr < 8'h80;
  endsequence

  a_resp_on_req: assert property (chkReq.valid |=> chkResp.valid)
    else $error("verdict missing one cycle after access");
  a_resp_idle: assert property (!chkReq.valid |=> !chkResp.valid)
    else $error("verdict without access");
  a_fault_kind: assert property (chkReq.valid |=>
    chkResp.faultKind == $past(chkReq.kind))
    else $error("fault kind differs from access kind");
  a_read_stands: assert property (!regRd |=> regRdData == 32'h0)
    else $error("read data outside its cycle");
  a_cfg_legal: assert property (cfgRead |=> regRdData[31:8] == 24'h0 &&
    regRdData[6:5] == 2'h0 && regRdData[1:0] != 2'h2 &&
    regRdData[4:3] != 2'h2)
    else $error("illegal configuration readback");
  a_addr_shape: assert property (addrRead |=> regRdData[1:0] != 2'h2)
    else $error("address low bits not shaped");
  a_unmapped_zero: assert property (regRd && regAddr >= 8'h84 |=>
    regRdData == 32'h0)
    else $error("unmapped read not zero");
  a_default_verdict: assert property (!wrSeen && chkReq.valid |=>
    chkResp.fault == ($past(chkReq.priv) != pmc_pkg::PRIV_M ||
    $past(chkReq.walk)))
    else $error("default verdict wrong");
endmodule

bind pmc_checker pmc_checker_monitor u_mon (
  .ref_clk  (ref_clk),
  .rst      (rst),
  .regAddr  (regAddr),
  .regWrData(regWrData),
  .regWr    (regWr),
  .regRd    (regRd),
  .regRdData(regRdData),
  .chkReq   (chkReq),
  .chkResp  (chkResp)
);

`default_nettype wire

/* File: pmc_hart_model.sv */
// Hart access paths: issues one fetch, load, store or walk and takes the
// verdict. Assumes callers enter issue() right after a rising edge.
`default_nettype none

module pmc_hart_model (
  // Clock
  input wire logic               ref_clk,
  // Access path
  output var pmc_pkg::pmc_req_t  chkReq,
  input wire pmc_pkg::pmc_resp_t chkResp
);
  timeunit 1ns;
  timeprecision 1ns;

  // Idle bus at time zero
  initial begin
    chkReq = '0;
  end

  // One access: held for the taking edge, verdict taken one edge later
  task automatic issue(input logic [1:0] k, input logic w,
                       input logic [1:0] p, input logic [33:0] a,
                       input logic [1:0] s, output pmc_pkg::pmc_resp_t r);
    chkReq <= {1'b1, k, w, p, a, s};
    @(posedge ref_clk);
    // Released fields flip so stale values never look valid
    chkReq <= {1'b0, ~chkReq[40:0]};
    @(posedge ref_clk);
    r = chkResp;
  endtask

  // After entries change, one quiet edge so no check sees stale entries
  task automatic fence();
    @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

/* File: testbench.sv */
// Self-checking bench for pmc_checker: register port tasks and scenarios.
// Assumes pmc_hart_model drives the access port.
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ns;

  // Short names for kinds and privileges
  localparam logic [1:0] FE = pmc_pkg::KIND_FETCH;
  localparam logic [1:0] LD = pmc_pkg::KIND_LOAD;
  localparam logic [1:0] ST = pmc_pkg::KIND_STORE;
  localparam logic [1:0] U  = pmc_pkg::PRIV_U;
  localparam logic [1:0] S  = pmc_pkg::PRIV_S;
  localparam logic [1:0] M  = pmc_pkg::PRIV_M;

  logic               ref_clk;
  logic               rst;
  logic [7:0]         regAddr;
  logic [31:0]        regWrData;
  logic               regWr;
  logic               regRd;
  logic [31:0]        regRdData;
  pmc_pkg::pmc_req_t  chkReq;
  pmc_pkg::pmc_resp_t chkResp;
  int                 errors;
  int                 checkCount;
  int                 cycles;

  pmc_checker u_dut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .chkReq(chkReq), .chkResp(chkResp));
  pmc_hart_model u_hart (.ref_clk(ref_clk), .chkReq(chkReq),
    .chkResp(chkResp));

  // 100 ns clock
  initial begin
    ref_clk = 1'b0;
  end
  always #50 ref_clk = ~ref_clk;

  // Runs take about 120 cycles; a hang stops here
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      giveVerdict();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
    @(posedge ref_clk);
  endtask

  // Read and compare; data stands only in the cycle after the strobe
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    @(posedge ref_clk);
    chk(regRdData, e);
  endtask

  task automatic acc(input logic [1:0] k, input logic [1:0] p,
                     input logic w, input logic [33:0] a,
                     input logic [1:0] s, input logic ef);
    pmc_pkg::pmc_resp_t r;
    u_hart.issue(k, w, p, a, s, r);
    chk({28'h0, r}, {28'h0, 1'b1, ef, k});
  endtask

  task automatic t_defaults();
    rc(8'h00, 32'h0);
    rc(8'h90, 32'h0);
    acc(LD, M, 1'b0, 34'h100, 2'h2, 1'b0);
    acc(LD, U, 1'b0, 34'h100, 2'h2, 1'b1);
    acc(LD, M, 1'b1, 34'h100, 2'h2, 1'b1);
  endtask

  task automatic t_grain();
    wr(8'h00, 32'h08);
    wr(8'h00, 32'h10);
    rc(8'h00, 32'h08);
    wr(8'h00, 32'h7a);
    rc(8'h00, 32'h18);
    wr(8'h00, 32'h0);
    wr(8'h40, 32'hffffffff);
    rc(8'h40, 32'hfffffffc);
    wr(8'h00, 32'h18);
    rc(8'h40, 32'hffffffff);
    wr(8'h00, 32'h07);
    rc(8'h40, 32'hfffffffc);
    acc(LD, S, 1'b0, 34'h100, 2'h2, 1'b1);
    wr(8'h00, 32'h18);
    rc(8'h40, 32'hffffffff);
  endtask

  // Top bound 0x100, 64-byte region at 0x1000, top range to 0x2000
  task automatic t_match();
    wr(8'h40, 32'h43);
    wr(8'h00, 32'h09);
    wr(8'h44, 32'h407);
    wr(8'h04, 32'h1f);
    wr(8'h48, 32'h800);
    wr(8'h08, 32'h08);
    wr(8'h4c, 32'h100);
    wr(8'h0c, 32'h0f);
    u_hart.fence();
    acc(LD, S, 1'b0, 34'h0, 2'h3, 1'b0);
    acc(ST, S, 1'b0, 34'h0, 2'h2, 1'b1);
    acc(FE, S, 1'b0, 34'h80, 2'h2, 1'b1);
    acc(LD, S, 1'b0, 34'hfc, 2'h2, 1'b0);
    acc(LD, S, 1'b0, 34'hfc, 2'h3, 1'b1);
    acc(LD, S, 1'b0, 34'h100, 2'h2, 1'b1);
    acc(ST, S, 1'b0, 34'h1000, 2'h3, 1'b0);
    acc(ST, U, 1'b0, 34'h103c, 2'h2, 1'b0);
    acc(LD, S, 1'b0, 34'h1020, 2'h2, 1'b0);
    acc(LD, S, 1'b0, 34'h1040, 2'h2, 1'b1);
    rc(8'h80, 32'h0001_0203);
    acc(LD, M, 1'b0, 34'h1800, 2'h2, 1'b0);
    acc(LD, S, 1'b0, 34'h200, 2'h2, 1'b1);
  endtask

  task automatic t_lock();
    wr(8'h50, 32'hc00);
    wr(8'h10, 32'h88);
    u_hart.fence();
    acc(LD, M, 1'b0, 34'h2800, 2'h2, 1'b1);
    wr(8'h50, 32'h0);
    rc(8'h50, 32'hc00);
    wr(8'h10, 32'h0);
    rc(8'h10, 32'h88);
    wr(8'h4c, 32'h0);
    rc(8'h4c, 32'h100);
    wr(8'h14, 32'h80);
    wr(8'h14, 32'h1f);
    rc(8'h14, 32'h80);
    rst <= 1'b1;
    @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    rc(8'h10, 32'h0);
  endtask

  task automatic giveVerdict();
    $display("errors=%0d checks=%0d", errors, checkCount);
    if (errors == 0 && checkCount > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Reset for six cycles, then the scenarios in order
  initial begin
    rst = 1'b1;
    regAddr = 8'h0;
    regWrData = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_defaults();
    t_grain();
    t_match();
    t_lock();
    giveVerdict();
  end
endmodule

`default_nettype wire
